// file: design/rbs_exec_regs.vh
`ifndef RBS_EXEC_REGS_VH
`define RBS_EXEC_REGS_VH
`define RBS_OPC_JUMP      4'hD
`define RBS_OPC_JUMP_B11  1'h0
`define RBS_OPC_SETBIT    4'h8
`define RBS_IDX_LIMIT     8'h5F
`define RBS_ACC_SPLIT     8'h80
`define RBS_ACC_HI_BANK   4'hF
`define RBS_ACC_LO_BANK   4'h0
`define RBS_Q1            2'h0
`define RBS_Q2            2'h1
`define RBS_Q3            2'h2
`define RBS_Q4            2'h3
`define RBS_OPC_HI        15
`define RBS_OPC_LO        12
`define RBS_JUMP_SEL      11
`define RBS_OFFS_HI       10
`define RBS_BIT_HI        11
`define RBS_BIT_LO        9
`define RBS_BANK_POS      8
`define RBS_FILE_HI       7
`define RBS_RST_ADDR      12'h000
`define RBS_RST_BYTE      8'h00
`endif

// file: design/rbs_exec.v
`timescale 1ns/100ps
`default_nettype none
`include "rbs_exec_regs.vh"
module rbs_exec #(
	parameter PC_W = 21
) (
	input  wire             clk_i,
	input  wire             srst_i,
	input  wire [1:0]       q_phase_i,
	input  wire [15:0]      instr_i,
	input  wire [PC_W-1:0]  pc_i,
	input  wire [3:0]       bank_select_register_i,
	input  wire             ext_set_en_i,
	input  wire [11:0]      fsr2_i,
	input  wire [7:0]       rd_data_i,
	output reg  [11:0]      addr_o,
	output reg              rd_o,
	output reg              wr_o,
	output reg  [7:0]       wr_data_o,
	output reg  [PC_W-1:0]  pc_load_o,
	output reg              pc_load_en_o,
	output reg              flush_o,
	output wire             status_wr_o
);
	// ----------------------------------------
	// Field widths
	// ----------------------------------------
	localparam OPC_W  = 4;
	localparam BIT_W  = 3;
	localparam FILE_W = 8;
	localparam OFFS_W = 11;
	localparam ADDR_W = 12;
	localparam MASK_W = 8;

	// ----------------------------------------
	// Instruction fields
	// ----------------------------------------
	wire [OPC_W-1:0]  opcode;
	wire              jump_sel;
	wire [BIT_W-1:0]  bitnum;
	wire              bank_f;
	wire [FILE_W-1:0] faddr;
	wire [OFFS_W-1:0] offs;
	wire [PC_W-1:0]   target;
	wire [MASK_W-1:0] bit_mask;

	assign opcode   = instr_i[`RBS_OPC_HI:`RBS_OPC_LO];
	assign jump_sel = instr_i[`RBS_JUMP_SEL];
	assign bitnum   = instr_i[`RBS_BIT_HI:`RBS_BIT_LO];
	assign bank_f   = instr_i[`RBS_BANK_POS];
	assign faddr    = instr_i[`RBS_FILE_HI:0];
	assign offs     = instr_i[`RBS_OFFS_HI:0];

	// ----------------------------------------
	// Control and datapath state
	// ----------------------------------------
	reg               in_flush;
	reg  [7:0]        latched;
	reg               is_jump;
	reg               is_setbit;
	reg  [11:0]       ea;
	reg               next_in_flush;
	reg  [7:0]        next_latched;
	reg  [11:0]       next_addr;
	reg               next_rd;
	reg               next_wr;
	reg  [7:0]        next_wr_data;
	reg  [PC_W-1:0]   next_pc_load;
	reg               next_pc_load_en;
	reg               next_flush;

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	function opc_match;
		input [3:0] op;
		input [3:0] code;
		begin
			opc_match = (op == code);
		end
	endfunction

	function [PC_W-1:0] jump_disp;
		input [10:0] n;
		begin
			jump_disp = {{(PC_W-OFFS_W-1){n[`RBS_OFFS_HI]}}, n, 1'h0};
		end
	endfunction

	function [11:0] eff_addr;
		input [7:0]  f;
		input        a;
		input [3:0]  bank_select_register;
		input        ext;
		input [11:0] fsr;
		begin
			if (a) begin
				eff_addr = {bank_select_register, f};
			end else if (ext && f <= `RBS_IDX_LIMIT) begin
				eff_addr = fsr + {4'h0, f};
			end else if (f < `RBS_ACC_SPLIT) begin
				eff_addr = {`RBS_ACC_LO_BANK, f};
			end else begin
				eff_addr = {`RBS_ACC_HI_BANK, f};
			end
		end
	endfunction

	// ----------------------------------------
	// Jump target
	// ----------------------------------------
	assign target = pc_i + jump_disp(offs);

	// ----------------------------------------
	// Bit mask
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < MASK_W; gi = gi + 1) begin : g_mask
			localparam [BIT_W-1:0] BIT_IDX = gi;
			assign bit_mask[gi] = (bitnum == BIT_IDX);
		end
	endgenerate

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	always @* begin
		is_jump   = !in_flush && opc_match(opcode, `RBS_OPC_JUMP)
			&& (jump_sel == `RBS_OPC_JUMP_B11);
		is_setbit = !in_flush && opc_match(opcode, `RBS_OPC_SETBIT);
		ea        = eff_addr(faddr, bank_f, bank_select_register_i, ext_set_en_i, fsr2_i);
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	assign status_wr_o = 1'h0;

	// ----------------------------------------
	// Phase sequencing
	// ----------------------------------------
	always @* begin
		next_in_flush   = in_flush;
		next_latched    = latched;
		next_addr       = addr_o;
		next_rd         = 1'h0;
		next_wr         = 1'h0;
		next_wr_data    = wr_data_o;
		next_pc_load    = pc_load_o;
		next_pc_load_en = 1'h0;
		next_flush      = flush_o;
		case (q_phase_i)
			`RBS_Q1: begin
				if (is_setbit) begin
					next_addr = ea;
					next_rd   = 1'h1;
				end
			end
			`RBS_Q2: begin
				if (is_setbit) begin
					next_latched = rd_data_i;
				end
			end
			`RBS_Q3: begin
				if (is_setbit) begin
					next_wr_data = latched | bit_mask;
					next_wr      = 1'h1;
				end
				if (is_jump) begin
					next_pc_load    = target;
					next_pc_load_en = 1'h1;
				end
			end
			`RBS_Q4: begin
				next_in_flush = is_jump;
				next_flush    = is_jump;
			end
			default: begin
				next_in_flush = in_flush;
			end
		endcase
	end

	// ----------------------------------------
	// Strobe registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			rd_o         <= 1'h0;
			wr_o         <= 1'h0;
			pc_load_en_o <= 1'h0;
			flush_o      <= 1'h0;
			in_flush     <= 1'h0;
		end else begin
			rd_o         <= next_rd;
			wr_o         <= next_wr;
			pc_load_en_o <= next_pc_load_en;
			flush_o      <= next_flush;
			in_flush     <= next_in_flush;
		end
	end

	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			latched   <= `RBS_RST_BYTE;
			addr_o    <= `RBS_RST_ADDR;
			wr_data_o <= `RBS_RST_BYTE;
			pc_load_o <= {PC_W{1'h0}};
		end else begin
			latched   <= next_latched;
			addr_o    <= next_addr;
			wr_data_o <= next_wr_data;
			pc_load_o <= next_pc_load;
		end
	end
endmodule
`default_nettype wire

// file: sim/rbs_exec_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rbs_chk #(parameter PC_W = 21) (
	input wire logic            clk_i, srst_i, rd_o, wr_o, pc_load_en_o,
	input wire logic            flush_o, status_wr_o, ext_set_en_i,
	input wire logic [1:0]      q_phase_i,
	input wire logic [15:0]     instr_i,
	input wire logic [PC_W-1:0] pc_i, pc_load_o,
	input wire logic [3:0]      bank_select_register_i,
	input wire logic [11:0]     fsr2_i, addr_o,
	input wire logic [7:0]      rd_data_i, wr_data_o);
	wire [7:0] f  = instr_i[7:0];
	wire       sb = q_phase_i == 2'h0 && instr_i[15:12] == 4'h8 && !flush_o;
	wire       ix = ext_set_en_i && f <= 8'h5F;
	wire       jp = q_phase_i == 2'h2 && instr_i[15:11] == 5'h1A && !flush_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_read_q2: assert property (sb |=> rd_o ##1 !rd_o) else $error("read");
	a_bit_set: assert property (rd_o |-> ##2 wr_o &&
		wr_data_o == ($past(rd_data_i, 2) | 8'h01 << instr_i[11:9])) else $error("write");
	a_bank_addr: assert property (sb && instr_i[8] |=>
		addr_o == {$past(bank_select_register_i), f}) else $error("bank");
	a_access_addr: assert property (sb && !instr_i[8] && !ix |=>
		addr_o == {{4{f[7]}}, f}) else $error("access");
	a_index_addr: assert property (sb && !instr_i[8] && ix |=>
		addr_o == $past(fsr2_i) + f) else $error("index");
	a_jump_target: assert property (jp |=> pc_load_en_o && pc_load_o ==
		$past(pc_i) + {{(PC_W-12){instr_i[10]}}, instr_i[10:0], 1'h0}) else $error("jump");
	a_flush_len: assert property (pc_load_en_o |=> flush_o [*4]) else $error("flush");
	a_flush_quiet: assert property (flush_o |-> !rd_o && !wr_o && !pc_load_en_o)
		else $error("discard");
	a_no_flags: assert property (!status_wr_o) else $error("flags");
	cover property (sb && ix);
	cover property (jp);
	cover property (flush_o && instr_i[15:12] == 4'h8);
endmodule
`default_nettype wire

// file: sim/rbs_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("Error %0t got %h", $time, a); end end
module rbs_exec_bench;
	logic        clk_i = 0, srst_i = 1, ext_set_en_i = 0, rd_o, wr_o;
	logic        pc_load_en_o, flush_o, status_wr_o;
	logic [1:0]  q_phase_i = 0;
	logic [15:0] instr_i = 0;
	logic [20:0] pc_i = 21'h001000, pc_load_o;
	logic [3:0]  bank_select_register_i = 4'h3;
	logic [11:0] fsr2_i = 12'h100, addr_o;
	logic [7:0]  rd_data_i = 0, wr_data_o;
	int          errors = 0, tests_run = 0;
	logic [47:0] rows [4] = '{48'h8F4500A3458A, 48'h80FF1FEFFFFF, 48'h8E5F10015F80,
		48'h8A1005501075};
	rbs_exec u_dut (.*);
	always #25 clk_i = ~clk_i;
	always @(negedge clk_i) q_phase_i <= srst_i ? 2'h0 : q_phase_i + 2'h1;
	task op(input logic [15:0] i, input logic [7:0] d);
		instr_i <= i;
		rd_data_i <= d;
		repeat (4) @(negedge clk_i);
	endtask
	task test_done;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk_i);
		`CK({wr_data_o, pc_load_en_o, flush_o}, 10'h000)
		srst_i <= 0;
		foreach (rows[k]) begin
			ext_set_en_i <= rows[k][28];
			op(rows[k][47:32], rows[k][27:20]);
			`CK({addr_o, wr_data_o}, rows[k][19:0])
		end
		op(16'hD3FF, 8'h00);
		`CK({pc_load_o, flush_o}, {21'h0017FE, 1'h1})
		op(16'h8F45, 8'h00);
		`CK(wr_data_o, 8'h75)
		op(16'hD400, 8'h00);
		`CK(pc_load_o, 21'h000800)
		op(16'h0000, 8'h00);
		instr_i <= 16'hD001;
		repeat (3) @(negedge clk_i);
		`CK({pc_load_en_o, pc_load_o}, 22'h201002)
		srst_i <= 1'h1;
		@(negedge clk_i);
		`CK({rd_o, wr_o, pc_load_en_o, flush_o, pc_load_o}, 25'h0000000)
		srst_i <= 1'h0;
		op(16'h8F45, 8'h0A);
		`CK({addr_o, wr_data_o}, 20'h3458A)
		op(16'hD800, 8'h00);
		`CK({pc_load_o, flush_o}, 22'h000000)
		test_done;
	end
endmodule
bind rbs_exec rbs_chk #(.PC_W(PC_W)) u_chk (.*);
`default_nettype wire
